// File: core/calendar_rtc_alarm_core.sv
// calendar real-time clock with field-masked alarm, ready window and apb registers
//
// How it works
// [RULE1] seconds to year counters, each but weekday carrying into the next one up
// [RULE2] any year divisible by four counts as leap year
// [RULE3] first prescaler counts oscillator edges; its wrap clocks the second
// [RULE4] second prescaler divides by 128, its wrap is the one-second tick
// [RULE5] format bit one means bcd counting, zero binary; switchable live
// [RULE6] hold bit freezes both prescalers and every calendar counter
// [RULE7] alarm compares minute, hour, weekday, monthday, each with enable
// [RULE8] alarm flag sets on the tick reaching enabled values at second zero
// [RULE9] weekday compare joins hour and minute in the match
// [RULE10] monthday compare joins hour and minute in the match
// [RULE11] software clears alarm registers and enables before first alarm
// [RULE12] software disables alarm before loading new time values
// [RULE13] alarm values are not checked; software writes valid ones
// [RULE14] out-of-range time or alarm writes give undefined behaviour
// [RULE15] calendar counters update exactly once per second tick
// [RULE16] ready bit low for 128 oscillator cycles centred on update
// [RULE17] rising ready edge sets ready flag; enable routes it to irq
// [RULE18] ready flag clears on irq acknowledge or by software
// [RULE19] software ignores counter reads taken while ready is low
// [RULE20] software votes over repeated prescaler reads
// [RULE21] counter write applies at once and clears both prescalers
// [RULE22] software loads all registers before trusting the clock
// [RULE23] alarm flag requests interrupt only with alarm enable set
// [RULE24] monthday rolls to one after month end, february by leap rule
`timescale 1ns/10ps
`default_nettype none
`include "rtc_core_params.svh"
module calendar_rtc_alarm_core (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic lf_osc_clk,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ready_irq_ack,
  output logic irq
);
  import rtc_core_pkg::*;

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic [7:0] to_fmt(input logic [7:0] v, input logic bcd);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = v / 8'h0A;
    ones = v % 8'h0A;
    to_fmt = bcd ? {tens[3:0], ones[3:0]} : v;
  endfunction

  function automatic logic [7:0] from_fmt(input logic [7:0] v, input logic bcd);
    logic [7:0] tens;
    tens = {4'h0, v[7:4]};
    from_fmt = bcd ? 8'(tens * 8'h0A + {4'h0, v[3:0]}) : v;
  endfunction

  // one step up, digit-wise carry in bcd
  function automatic logic [15:0] inc_val(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic c;
    r = v;
    c = 1'b1;
    if (!bcd) begin
      r = v + 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (c) begin
          if (r[i*4 +: 4] == 4'h9) begin
            r[i*4 +: 4] = 4'h0;
          end else begin
            r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
            c = 1'b0;
          end
        end
      end
    end
    inc_val = r;
  endfunction

  // returns {carry, next value} for a field with binary limits
  function automatic logic [8:0] roll(input logic [7:0] v, input logic [7:0] last_bin,
                                      input logic [7:0] first_bin, input logic bcd);
    logic [15:0] w;
    w = inc_val({8'h00, v}, bcd);
    if (v == to_fmt(last_bin, bcd)) begin
      roll = {1'b1, to_fmt(first_bin, bcd)};
    end else begin
      roll = {1'b0, w[7:0]};
    end
  endfunction

  function automatic logic [7:0] days_in(input logic [7:0] month_bin, input logic leap);
    logic [7:0] d;
    d = `DAYS_31;
    if (month_bin == `FEB_NUM) begin
      d = leap ? `DAYS_29 : `DAYS_28; // [RULE24]
    end else if (month_bin == `APR_NUM || month_bin == `JUN_NUM ||
                 month_bin == `SEP_NUM || month_bin == `NOV_NUM) begin
      d = `DAYS_30;
    end
    days_in = d;
  endfunction

  function automatic logic field_ok(input alarm_field_t f, input logic [7:0] v);
    field_ok = !f.en || (f.val == v[6:0]);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'b00) && (a <= `ADDR_LAST);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic hold;
  logic fmt_bcd;
  logic rdy_ie;
  logic alm_ie;
  logic ready_flag;
  logic alarm_flag;
  logic ready_q;
  cal_time_t now;
  alarm_field_t amin;
  alarm_field_t ahour;
  alarm_field_t awday;
  alarm_field_t amday;

  logic next_hold;
  logic next_fmt_bcd;
  logic next_rdy_ie;
  logic next_alm_ie;
  logic next_ready_flag;
  logic next_alarm_flag;
  cal_time_t next_now;
  cal_time_t stepped;
  alarm_field_t next_amin;
  alarm_field_t next_ahour;
  alarm_field_t next_awday;
  alarm_field_t next_amday;
  logic [31:0] next_prdata;

  logic lf_edge;
  logic sec_tick;
  logic presc_clear;
  presc_count_t presc;
  logic ready_bit;
  logic leap;
  logic alarm_hit;
  logic any_en;
  logic wr;
  logic rd_setup;
  logic [8:0] r;
  logic [7:0] ctrl_rd;

  // ****************************************
  // oscillator edge and prescaler chain
  // ****************************************
  lf_edge_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .lf_pin(lf_osc_clk),
    .lf_edge(lf_edge)
  );

  rtc_prescaler u_presc (
    .mclk(mclk),
    .reset_n(reset_n),
    .lf_edge(lf_edge),
    .hold(hold),
    .clear(presc_clear),
    .count(presc),
    .sec_tick(sec_tick)
  );

  // ****************************************
  // ready window and interrupt request
  // ****************************************
  // 64 oscillator cycles either side of the second wrap
  assign ready_bit = !((presc.second == `PS_SECOND_LAST && presc.first >= `KEEPOUT_START) ||
                       (presc.second == 7'h00 && presc.first < `KEEPOUT_END)); // [RULE16]
  assign irq = (ready_flag && rdy_ie) || (alarm_flag && alm_ie); // [RULE17] [RULE23]

  // ****************************************
  // apb decode
  // ****************************************
  // zero wait states; read data captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign wr = psel && penable && pwrite && addr_mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign presc_clear = wr && paddr >= `ADDR_SEC && paddr <= `ADDR_YEAR; // [RULE21]

  // ****************************************
  // calendar stepping
  // ****************************************
  always_comb begin
    stepped = now;
    r = '0;
    leap = fmt_bcd ? (from_fmt(now.year[7:0], 1'b1) & 8'h03) == 8'h00
                   : now.year[1:0] == 2'b00; // [RULE2]
    r = roll(now.sec, `SEC_LAST, `ZERO_FIRST, fmt_bcd); // [RULE1] [RULE5]
    stepped.sec = r[7:0];
    if (r[8]) begin
      r = roll(now.min, `MIN_LAST, `ZERO_FIRST, fmt_bcd); // [RULE1]
      stepped.min = r[7:0];
      if (r[8]) begin
        r = roll(now.hour, `HOUR_LAST, `ZERO_FIRST, fmt_bcd);
        stepped.hour = r[7:0];
        if (r[8]) begin
          r = roll(now.wday, `WDAY_LAST, `ZERO_FIRST, fmt_bcd);
          stepped.wday = r[7:0];
          r = roll(now.mday, days_in(from_fmt(now.month, fmt_bcd), leap),
                   `ONE_FIRST, fmt_bcd); // [RULE24]
          stepped.mday = r[7:0];
          if (r[8]) begin
            r = roll(now.month, `MON_LAST, `ONE_FIRST, fmt_bcd);
            stepped.month = r[7:0];
            if (r[8]) begin
              stepped.year = inc_val(now.year, fmt_bcd); // [RULE1]
            end
          end
        end
      end
    end
    // an empty enable set never fires
    any_en = amin.en || ahour.en || awday.en || amday.en; // [RULE7]
    alarm_hit = sec_tick && any_en && stepped.sec == 8'h00 && // [RULE8]
                field_ok(amin, stepped.min) && field_ok(ahour, stepped.hour) &&
                field_ok(awday, stepped.wday) && // [RULE9]
                field_ok(amday, stepped.mday); // [RULE10]
  end

  // ****************************************
  // register next values
  // ****************************************
  always_comb begin
    next_hold = hold;
    next_fmt_bcd = fmt_bcd;
    next_rdy_ie = rdy_ie;
    next_alm_ie = alm_ie;
    next_now = sec_tick ? stepped : now; // [RULE15]
    next_amin = amin;
    next_ahour = ahour;
    next_awday = awday;
    next_amday = amday;
    next_ready_flag = ready_flag;
    next_alarm_flag = alarm_flag;
    next_prdata = prdata;
    ctrl_rd = '0;
    if (wr) begin
      unique case (paddr)
        `ADDR_CTRL: begin
          next_hold = pwdata[`CTRL_HOLD]; // [RULE6]
          next_fmt_bcd = pwdata[`CTRL_BCD]; // [RULE5]
          next_rdy_ie = pwdata[`CTRL_RDY_IE];
          next_alm_ie = pwdata[`CTRL_ALM_IE];
          if (pwdata[`CTRL_RDY_FLAG]) begin
            next_ready_flag = 1'b0; // [RULE18]
          end
          if (pwdata[`CTRL_ALM_FLAG]) begin
            next_alarm_flag = 1'b0;
          end
        end
        // a counter write overrides only its own field of a tick landing in the same cycle
        `ADDR_SEC: next_now.sec = pwdata[7:0]; // [RULE21]
        `ADDR_MIN: next_now.min = pwdata[7:0];
        `ADDR_HOUR: next_now.hour = pwdata[7:0];
        `ADDR_WDAY: next_now.wday = pwdata[7:0];
        `ADDR_MDAY: next_now.mday = pwdata[7:0];
        `ADDR_MON: next_now.month = pwdata[7:0];
        `ADDR_YEAR: next_now.year = pwdata[15:0];
        `ADDR_AMIN: next_amin = pwdata[7:0]; // [RULE7]
        `ADDR_AHOUR: next_ahour = pwdata[7:0];
        `ADDR_AWDAY: next_awday = pwdata[7:0];
        `ADDR_AMDAY: next_amday = pwdata[7:0];
        default: begin
        end
      endcase
    end
    if (ready_irq_ack) begin
      next_ready_flag = 1'b0; // [RULE18]
    end
    // hardware set wins over any clear in the same cycle
    if (ready_bit && !ready_q) begin
      next_ready_flag = 1'b1; // [RULE17]
    end
    if (alarm_hit) begin
      next_alarm_flag = 1'b1; // [RULE8]
    end
    ctrl_rd[`CTRL_HOLD] = hold;
    ctrl_rd[`CTRL_BCD] = fmt_bcd;
    ctrl_rd[`CTRL_RDY_IE] = rdy_ie;
    ctrl_rd[`CTRL_ALM_IE] = alm_ie;
    ctrl_rd[`CTRL_RDY_BIT] = ready_bit; // [RULE16]
    ctrl_rd[`CTRL_RDY_FLAG] = ready_flag;
    ctrl_rd[`CTRL_ALM_FLAG] = alarm_flag;
    if (rd_setup) begin
      unique case (paddr)
        `ADDR_CTRL: next_prdata = {24'h000000, ctrl_rd};
        `ADDR_SEC: next_prdata = {24'h000000, now.sec};
        `ADDR_MIN: next_prdata = {24'h000000, now.min};
        `ADDR_HOUR: next_prdata = {24'h000000, now.hour};
        `ADDR_WDAY: next_prdata = {24'h000000, now.wday};
        `ADDR_MDAY: next_prdata = {24'h000000, now.mday};
        `ADDR_MON: next_prdata = {24'h000000, now.month};
        `ADDR_YEAR: next_prdata = {16'h0000, now.year};
        `ADDR_AMIN: next_prdata = {24'h000000, amin};
        `ADDR_AHOUR: next_prdata = {24'h000000, ahour};
        `ADDR_AWDAY: next_prdata = {24'h000000, awday};
        `ADDR_AMDAY: next_prdata = {24'h000000, amday};
        // unguarded by the ready window; software must vote
        `ADDR_PRESC: next_prdata = {17'h00000, presc.second, presc.first};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold <= 1'b0;
      fmt_bcd <= 1'b0;
      rdy_ie <= 1'b0;
      alm_ie <= 1'b0;
      ready_flag <= 1'b0;
      alarm_flag <= 1'b0;
      ready_q <= 1'b1;
      now <= {`RST_YEAR, `RST_DAY, `RST_DAY, `RST_BYTE, `RST_BYTE, `RST_BYTE, `RST_BYTE};
      amin <= `RST_BYTE;
      ahour <= `RST_BYTE;
      awday <= `RST_BYTE;
      amday <= `RST_BYTE;
      prdata <= 32'h00000000;
    end else begin
      hold <= next_hold;
      fmt_bcd <= next_fmt_bcd;
      rdy_ie <= next_rdy_ie;
      alm_ie <= next_alm_ie;
      ready_flag <= next_ready_flag;
      alarm_flag <= next_alarm_flag;
      ready_q <= ready_bit;
      now <= next_now;
      amin <= next_amin;
      ahour <= next_ahour;
      awday <= next_awday;
      amday <= next_amday;
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// File: inc/rtc_core_params.svh
// constants for the calendar clock core: register map, field positions, limits
`ifndef RTC_CORE_PARAMS_SVH
`define RTC_CORE_PARAMS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_CTRL 8'h00
`define ADDR_SEC 8'h04
`define ADDR_MIN 8'h08
`define ADDR_HOUR 8'h0C
`define ADDR_WDAY 8'h10
`define ADDR_MDAY 8'h14
`define ADDR_MON 8'h18
`define ADDR_YEAR 8'h1C
`define ADDR_AMIN 8'h20
`define ADDR_AHOUR 8'h24
`define ADDR_AWDAY 8'h28
`define ADDR_AMDAY 8'h2C
`define ADDR_PRESC 8'h30
`define ADDR_LAST 8'h30

// ****************************************
// control, status, alarm enable and prescaler bit positions
// ****************************************
`define CTRL_HOLD 0
`define CTRL_BCD 1
`define CTRL_RDY_IE 2
`define CTRL_ALM_IE 3
`define CTRL_RDY_BIT 4
`define CTRL_RDY_FLAG 5
`define CTRL_ALM_FLAG 6
`define ALARM_EN_BIT 7
`define PRESC_SECOND_LSB 8

// ****************************************
// calendar limits, binary
// ****************************************
`define SEC_LAST 8'h3B
`define MIN_LAST 8'h3B
`define HOUR_LAST 8'h17
`define WDAY_LAST 8'h06
`define MON_LAST 8'h0C
`define ZERO_FIRST 8'h00
`define ONE_FIRST 8'h01
`define FEB_NUM 8'h02
`define APR_NUM 8'h04
`define JUN_NUM 8'h06
`define SEP_NUM 8'h09
`define NOV_NUM 8'h0B
`define DAYS_31 8'h1F
`define DAYS_30 8'h1E
`define DAYS_29 8'h1D
`define DAYS_28 8'h1C

// ****************************************
// prescaler chain
// ****************************************
`define PS_FIRST_LAST 8'hFF
`define PS_SECOND_LAST 7'h7F
`define KEEPOUT_START 8'hC0
`define KEEPOUT_END 8'h40

// ****************************************
// reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_YEAR 16'h0000
`define RST_DAY 8'h01

`endif

// File: inc/rtc_core_pkg.sv
// shared types of the calendar clock core
package rtc_core_pkg;

  // ****************************************
  // calendar, alarm and prescaler carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] year;
    logic [7:0] month;
    logic [7:0] mday;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } cal_time_t;

  typedef struct packed {
    logic en;
    logic [6:0] val;
  } alarm_field_t;

  typedef struct packed {
    logic [7:0] first;
    logic [6:0] second;
  } presc_count_t;

endpackage

// File: core/lf_edge_sync.sv
// two-stage synchroniser and rising-edge detector for the low-frequency clock pin
`timescale 1ns/10ps
`default_nettype none
module lf_edge_sync (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic lf_pin,
  output logic lf_edge
);
  logic meta;
  logic stable;
  logic stable_d;
  logic next_edge;

  // edge taken from the second stage only; the first stage feeds nothing else
  always_comb begin
    next_edge = stable & ~stable_d;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
      stable_d <= 1'b0;
      lf_edge <= 1'b0;
    end else begin
      meta <= lf_pin;
      stable <= meta;
      stable_d <= stable;
      lf_edge <= next_edge;
    end
  end
endmodule
`default_nettype wire

// File: core/rtc_prescaler.sv
// cascaded divide-by-256 and divide-by-128 prescalers giving a one-second tick
`timescale 1ns/10ps
`default_nettype none
`include "rtc_core_params.svh"
module rtc_prescaler (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic lf_edge,
  input wire logic hold,
  input wire logic clear,
  output rtc_core_pkg::presc_count_t count,
  output logic sec_tick
);
  import rtc_core_pkg::*;
  presc_count_t next_count;
  logic next_tick;
  logic first_wrap;

  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    first_wrap = (count.first == `PS_FIRST_LAST);
    if (clear) begin
      next_count = '0; // [RULE21]
    end else if (!hold && lf_edge) begin // [RULE6]
      next_count.first = count.first + 8'h01; // [RULE3]
      if (first_wrap) begin
        next_count.second = count.second + 7'h01; // [RULE3]
        next_tick = (count.second == `PS_SECOND_LAST); // [RULE4]
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      sec_tick <= 1'b0;
    end else begin
      count <= next_count;
      sec_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// File: verification/rtc_core_props.sv
// concurrent checks on the apb and interrupt ports of the calendar clock core
`timescale 1ns/10ps
`default_nettype none
module rtc_core_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic lf_osc_clk,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ready_irq_ack,
  input wire logic irq
);
  logic acc;
  logic bad_addr;
  assign acc = psel & penable;
  assign bad_addr = (paddr[1:0] != 2'h0) || (paddr > 8'h30);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ****************************************
  // bus answer
  // ****************************************
  property p_pready_high; acc |-> pready; endproperty
  a_pready_high: assert property (p_pready_high) else $error("pready low in access");
  property p_slverr_bad; acc && bad_addr |-> pslverr; endproperty
  a_slverr_bad: assert property (p_slverr_bad) else $error("unmapped access not refused");
  property p_slverr_good; acc && !bad_addr |-> !pslverr; endproperty
  a_slverr_good: assert property (p_slverr_good) else $error("mapped access refused");
  property p_slverr_idle; !acc |-> !pslverr; endproperty
  a_slverr_idle: assert property (p_slverr_idle) else $error("pslverr outside access");
  // read data only moves after a setup cycle
  property p_prdata_hold; !$past(psel && !penable) |-> $stable(prdata); endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("prdata moved without setup");
  property p_bad_zero; acc && !pwrite && bad_addr |-> prdata == 32'h00000000; endproperty
  a_bad_zero: assert property (p_bad_zero) else $error("unmapped read not zero");
  // ****************************************
  // interrupt and prescaler
  // ****************************************
  property p_irq_match;
    acc && !pwrite && paddr == 8'h00 |->
      irq == ((prdata[5] & prdata[2]) | (prdata[6] & prdata[3]));
  endproperty
  a_irq_match: assert property (p_irq_match) else $error("irq disagrees with flags");
  property p_presc_width; acc && !pwrite && paddr == 8'h30 |-> prdata[31:15] == 17'h00000;
  endproperty
  a_presc_width: assert property (p_presc_width) else $error("prescaler too wide");
  c_write: cover property (acc && pwrite && !bad_addr);
  c_refused: cover property (acc && pslverr);
  c_irq: cover property (irq);
endmodule
`default_nettype wire

// File: verification/lf_osc_model.sv
// low-frequency oscillator source; stands low between bursts
`timescale 1ns/10ps
`default_nettype none
module lf_osc_model (
  input wire logic mclk,
  output logic lf_osc_clk
);
  initial lf_osc_clk = 1'b0;
  // half period of 5 system cycles keeps the synchroniser margin
  task run(input int n);
    repeat (n) begin
      repeat (5) @(posedge mclk);
      lf_osc_clk <= 1'b1;
      repeat (5) @(posedge mclk);
      lf_osc_clk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: verification/calendar_rtc_alarm_core_tb.sv
// self-checking bench for the calendar clock core
`timescale 1ns/10ps
`default_nettype none
`include "rtc_core_params.svh"
module calendar_rtc_alarm_core_tb;
  logic mclk, reset_n, psel, penable, pwrite, ready_irq_ack;
  logic pready, pslverr, irq, lf_osc_clk;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [31:0] tv [7];
  logic [32:0] exp_q [$];
  logic [32:0] note;
  int err_total, n_checks, i;
  int lim [7] = '{60, 60, 24, 7, 28, 12, 199};
  int base [7] = '{0, 0, 0, 0, 1, 1, 1901};
  calendar_rtc_alarm_core u_calendar_rtc_alarm_core (.mclk(mclk), .reset_n(reset_n),
    .lf_osc_clk(lf_osc_clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ready_irq_ack(ready_irq_ack), .irq(irq));
  lf_osc_model u_lf_osc_model (.mclk(mclk), .lf_osc_clk(lf_osc_clk));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task wrap_up;
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // irq sampled mid-cycle, away from the edge that updates the flags
  task chk(input logic e);
    @(negedge mclk);
    n_checks++;
    if (irq !== e) begin
      err_total++;
      $display("[FAIL] %0t irq level wrong", $time);
    end
  endtask
  task apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      err_total++;
      $display("[FAIL] %0t no pready", $time);
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h000000000);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, {1'b0, e});
  endtask
  task osc(input int n);
    u_lf_osc_model.run(n);
    repeat (8) @(posedge mclk);
  endtask
  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      n_checks++;
      if (pslverr !== note[32] || (!pwrite && prdata !== note[31:0])) begin
        err_total++;
        $display("[FAIL] %0t addr 0x%0h got 0x%0h", $time, paddr, prdata);
      end
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ready_irq_ack = 1'b0;
    reset_n = 1'b0;
    seed = 32'h0001549E;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`ADDR_CTRL, 32'h00000000);
    rd(`ADDR_MDAY, 32'h00000001);
    rd(`ADDR_PRESC, 32'h00000000);
    wr(`ADDR_CTRL, 32'h00000000);
    for (i = 0; i < 4; i++) wr(8'(8'h20 + 4 * i), 32'h00000000);
    for (i = 0; i < 7; i++) begin
      tv[i] = xs() % 32'(lim[i]) + 32'(base[i]);
      wr(8'(4 + 4 * i), tv[i]);
    end
    for (i = 0; i < 7; i++) rd(8'(4 + 4 * i), tv[i]);
    wr(`ADDR_CTRL, 32'h00000006);
    osc(300);
    rd(`ADDR_PRESC, 32'h0000012C);
    rd(`ADDR_CTRL, 32'h00000036);
    chk(1'b1);
    @(posedge mclk);
    ready_irq_ack <= 1'b1;
    @(posedge mclk);
    ready_irq_ack <= 1'b0;
    rd(`ADDR_CTRL, 32'h00000016);
    chk(1'b0);
    wr(`ADDR_CTRL, 32'h00000007);
    osc(50);
    rd(`ADDR_PRESC, 32'h0000012C);
    rd(`ADDR_SEC, tv[0]);
    wr(`ADDR_CTRL, 32'h00000006);
    osc(100);
    rd(`ADDR_PRESC, 32'h00000190);
    wr(`ADDR_SEC, tv[0]);
    rd(`ADDR_PRESC, 32'h00000000);
    rd(`ADDR_CTRL, 32'h00000006);
    osc(64);
    rd(`ADDR_CTRL, 32'h00000036);
    wr(`ADDR_CTRL, 32'h00000026);
    rd(`ADDR_CTRL, 32'h00000016);
    wr(`ADDR_PRESC, 32'h00000000);
    rd(`ADDR_PRESC, 32'h00000040);
    rd(`ADDR_PRESC, 32'h00000040);
    apb(1'b0, 8'h34, 32'h00000000, 33'h100000000);
    apb(1'b1, 8'h34, 32'hFFFFFFFF, 33'h100000000);
    apb(1'b0, 8'h05, 32'h00000000, 33'h100000000);
    tv[1] = 32'h00000080 | (xs() % 32'd60);
    wr(`ADDR_AMIN, tv[1]);
    rd(`ADDR_AMIN, tv[1]);
    wr(`ADDR_AWDAY, 32'h00000082);
    rd(`ADDR_AWDAY, 32'h00000082);
    wr(`ADDR_AMDAY, 32'h00000085);
    rd(`ADDR_AMDAY, 32'h00000085);
    wr(`ADDR_CTRL, 32'h0000000E);
    chk(1'b0);
    repeat (4) @(posedge mclk);
    wrap_up();
  end
endmodule
bind calendar_rtc_alarm_core rtc_core_props u_rtc_core_props (.mclk(mclk), .reset_n(reset_n),
  .lf_osc_clk(lf_osc_clk), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ready_irq_ack(ready_irq_ack), .irq(irq));
`default_nettype wire
